// >>> sdd_defs.svh
// Purpose: constants for the segment descriptor decoder
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   offsets, field positions and reset values live here only
//
// How it works
// - Every descriptor is two words: base, limit and type, whatever its class.
// - Interrupt table has 256 entries, 8 bytes protected, 4 bytes real mode.
// - Storing the interrupt table register returns all of it, nothing hidden.
// - Loading the interrupt table register takes base as a linear address.
// - Interrupt table register holds a base field and a limit field.
// - Base assembled from three pieces in upper and lower descriptor words.
// - Limit assembled from upper bits at +4 and lower bits at +0.
// - Granularity one scales limit by 4 KB; zero counts bytes.
// - Code segment default size one means 32-bit operands, else 16-bit.
// - Data segment default size picks wide or narrow stack pointer.
// - Software-available flag is ignored by hardware.
// - Loading a non-present descriptor raises segment-not-present; no base or limit.
// - Privilege 00 is most privileged, 11 least privileged.
// - Class flag one means code or data; zero means system segment.
// - Type bit 11 is executable, bit 8 is accessed.
// - Type bit 10 is conforming for code/data, expand-down for system class.
// - Type bit 9 is readable for code/data, writable for system class.
// - System types decoded, e.g. 1001 available and 1011 busy 32-bit task state.
`ifndef SDD_DEFS_SVH
`define SDD_DEFS_SVH

`define SDD_ADDR_LO        12'h000
`define SDD_ADDR_HI        12'h004
`define SDD_ADDR_CTRL      12'h008
`define SDD_ADDR_BASE      12'h00C
`define SDD_ADDR_LIMIT     12'h010
`define SDD_ADDR_ATTR      12'h014
`define SDD_ADDR_TBL_BASE  12'h018
`define SDD_ADDR_TBL_LIM   12'h01C
`define SDD_ADDR_OFFSET    12'h020
`define SDD_ADDR_STATUS    12'h024

`define SDD_CTRL_LOAD      0
`define SDD_CTRL_PROT      1
`define SDD_CTRL_CHK_OFS   2
`define SDD_CTRL_CHK_VEC   3
`define SDD_CTRL_VEC_LSB   8
`define SDD_CTRL_VEC_MSB   15

`define SDD_BIT_G          23
`define SDD_BIT_D          22
`define SDD_BIT_AVL        20
`define SDD_BIT_P          15
`define SDD_DPL_MSB        14
`define SDD_DPL_LSB        13
`define SDD_BIT_S          12
`define SDD_TYPE_MSB       11
`define SDD_TYPE_LSB       8
`define SDD_BIT_EXEC       11
`define SDD_BIT_CE         10
`define SDD_BIT_RW         9
`define SDD_BIT_ACC        8

`define SDD_PAGE_SHIFT     12
`define SDD_PAGE_ONES      12'hFFF
`define SDD_ENT_SHIFT_PROT 3
`define SDD_ENT_SHIFT_REAL 2
`define SDD_ENT_LAST_PROT  32'h0000_0007
`define SDD_ENT_LAST_REAL  32'h0000_0003
`define SDD_TBL_LIM_RESET  16'hFFFF
`define SDD_ZERO32         32'h0000_0000

`define SDD_ST_TSS16_AV    4'h1
`define SDD_ST_LDT         4'h2
`define SDD_ST_TSS16_BSY   4'h3
`define SDD_ST_CALL16      4'h4
`define SDD_ST_TASK        4'h5
`define SDD_ST_INT16       4'h6
`define SDD_ST_TRAP16      4'h7
`define SDD_ST_TSS32_AV    4'h9
`define SDD_ST_TSS32_BSY   4'hB
`define SDD_ST_CALL32      4'hC
`define SDD_ST_INT32       4'hE
`define SDD_ST_TRAP32      4'hF

`endif

// >>> sdd_pkg.sv
// Purpose: types for the segment descriptor decoder
// Assumes: constants come from sdd_defs.svh
// Notes:   state is one packed struct
package sdd_pkg;

   typedef enum logic [1:0] {
      SDD_IDLE  = 2'b00,
      SDD_CHECK = 2'b01,
      SDD_DONE  = 2'b11
   } sdd_state_t;

   typedef enum logic [3:0] {
      SDD_SYS_RESERVED  = 4'h0,
      SDD_SYS_TSS16_AV  = 4'h1,
      SDD_SYS_LDT       = 4'h2,
      SDD_SYS_TSS16_BSY = 4'h3,
      SDD_SYS_CALL16    = 4'h4,
      SDD_SYS_TASK      = 4'h5,
      SDD_SYS_INT16     = 4'h6,
      SDD_SYS_TRAP16    = 4'h7,
      SDD_SYS_TSS32_AV  = 4'h9,
      SDD_SYS_TSS32_BSY = 4'hB,
      SDD_SYS_CALL32    = 4'hC,
      SDD_SYS_INT32     = 4'hE,
      SDD_SYS_TRAP32    = 4'hF
   } sdd_sys_t;

   typedef struct packed {
      sdd_state_t  state;
      logic [31:0] lo;
      logic [31:0] hi;
      logic        prot;
      logic        chk_ofs;
      logic        chk_vec;
      logic [7:0]  vec;
      logic [31:0] tbl_base;
      logic [15:0] tbl_lim;
      logic [31:0] offset;
      logic [31:0] seg_base;
      logic [31:0] seg_limit;
      logic        valid;
      logic        not_present;
      logic        limit_fault;
      logic        vec_fault;
      logic        busy;
      logic [31:0] vec_addr;
      logic        wide_ops;
      logic        wide_stack;
      logic [1:0]  descriptor_privilege_field;
      logic        most_priv;
      logic        code_data;
      logic        exec;
      logic        conforming;
      logic        expand_down;
      logic        readable;
      logic        writable;
      logic        accessed;
      logic [3:0]  sys_type;
      logic        tss_avail;
      logic        tss_busy;
      logic        is_gate;
      logic        fault_pulse;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } sdd_regs_t;

endpackage

// >>> sdd_decoder.sv
// Purpose: segment and interrupt descriptor decode with interrupt table register
// Assumes: APB slave, software writes descriptor words then pulses the load bit
// Notes:   one-cycle wait state on every APB access; decode result after 2 cycles
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdd_defs.svh"

module sdd_decoder
   import sdd_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   seg_not_present,
   output logic                   limit_fault,
   output logic                   vector_fault,
   output logic                   fault_pulse,
   output logic                   decode_valid,
   output logic                   wide_ops,
   output logic                   wide_stack,
   output logic [1:0]             desc_priv
);

   sdd_regs_t r_q;
   sdd_regs_t r_d;

   // Apply byte strobes to a word register
   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                   input logic [11:0]       off);
      return a == ADDR_W'(off);
   endfunction

   logic        acc;
   logic        wr;
   logic        mapped;
   logic [31:0] hi_w;
   logic [31:0] lo_w;
   logic [19:0] raw_lim;
   logic [31:0] scaled_lim;
   logic [31:0] ent_last;
   logic [31:0] ent_ofs;
   logic [31:0] status_w;
   logic [31:0] attr_w;

   always_comb begin
      hi_w = r_q.hi;
      lo_w = r_q.lo;
      acc  = psel && penable && !r_q.pready;
      wr   = acc && pwrite;
      mapped = is_reg(paddr, `SDD_ADDR_LO) || is_reg(paddr, `SDD_ADDR_HI)
            || is_reg(paddr, `SDD_ADDR_CTRL) || is_reg(paddr, `SDD_ADDR_BASE)
            || is_reg(paddr, `SDD_ADDR_LIMIT) || is_reg(paddr, `SDD_ADDR_ATTR)
            || is_reg(paddr, `SDD_ADDR_TBL_BASE) || is_reg(paddr, `SDD_ADDR_TBL_LIM)
            || is_reg(paddr, `SDD_ADDR_OFFSET) || is_reg(paddr, `SDD_ADDR_STATUS);
      raw_lim = {hi_w[19:16], lo_w[15:0]};
      // Page granularity fills the low 12 bits with ones so the last byte is covered
      if (hi_w[`SDD_BIT_G]) begin
         scaled_lim = {raw_lim, `SDD_PAGE_ONES};
      end else begin
         scaled_lim = {12'h000, raw_lim};
      end
      // Last byte of the selected entry must sit inside the table limit
      ent_ofs  = r_q.prot ? ({24'h00_0000, r_q.vec} << `SDD_ENT_SHIFT_PROT)
                          : ({24'h00_0000, r_q.vec} << `SDD_ENT_SHIFT_REAL);
      ent_last = ent_ofs + (r_q.prot ? `SDD_ENT_LAST_PROT : `SDD_ENT_LAST_REAL);
      status_w = {25'h000_0000, r_q.busy, r_q.fault_pulse, r_q.vec_fault,
                  r_q.limit_fault, r_q.not_present, r_q.valid, r_q.prot};
      attr_w = {13'h0000, r_q.tss_busy, r_q.tss_avail, r_q.is_gate, r_q.sys_type,
                r_q.accessed, r_q.writable, r_q.readable, r_q.expand_down,
                r_q.conforming, r_q.exec, r_q.code_data, r_q.most_priv, r_q.descriptor_privilege_field,
                r_q.wide_stack, r_q.wide_ops};

      r_d = r_q;
      r_d.pready      = 1'b0;
      r_d.pslverr     = 1'b0;
      r_d.fault_pulse = 1'b0;

      // APB: access phase answered one cycle after it starts
      if (acc) begin
         r_d.pready  = 1'b1;
         r_d.pslverr = !mapped;
         r_d.prdata  = `SDD_ZERO32;
         if (wr) begin
            if (is_reg(paddr, `SDD_ADDR_LO)) begin
               r_d.lo = strb_merge(r_q.lo, pwdata, pstrb);
            end
            if (is_reg(paddr, `SDD_ADDR_HI)) begin
               r_d.hi = strb_merge(r_q.hi, pwdata, pstrb);
            end
            if (is_reg(paddr, `SDD_ADDR_CTRL)) begin
               r_d.prot    = pwdata[`SDD_CTRL_PROT];
               r_d.chk_ofs = pwdata[`SDD_CTRL_CHK_OFS];
               r_d.chk_vec = pwdata[`SDD_CTRL_CHK_VEC];
               r_d.vec     = pwdata[`SDD_CTRL_VEC_MSB:`SDD_CTRL_VEC_LSB];
               if (pwdata[`SDD_CTRL_LOAD] && r_q.state == SDD_IDLE) begin
                  r_d.state = SDD_CHECK;
                  r_d.busy  = 1'b1;
               end
            end
            // Base taken as written: linear, no segment translation applied
            if (is_reg(paddr, `SDD_ADDR_TBL_BASE)) begin
               r_d.tbl_base = strb_merge(r_q.tbl_base, pwdata, pstrb);
            end
            if (is_reg(paddr, `SDD_ADDR_TBL_LIM)) begin
               r_d.tbl_lim = strb_merge({16'h0000, r_q.tbl_lim}, pwdata, pstrb)
                             [15:0];
            end
            if (is_reg(paddr, `SDD_ADDR_OFFSET)) begin
               r_d.offset = strb_merge(r_q.offset, pwdata, pstrb);
            end
         end else begin
            if (is_reg(paddr, `SDD_ADDR_LO)) r_d.prdata = r_q.lo;
            if (is_reg(paddr, `SDD_ADDR_HI)) r_d.prdata = r_q.hi;
            if (is_reg(paddr, `SDD_ADDR_CTRL)) begin
               r_d.prdata = {16'h0000, r_q.vec, 4'h0, r_q.chk_vec, r_q.chk_ofs,
                             r_q.prot, 1'b0};
            end
            if (is_reg(paddr, `SDD_ADDR_BASE))  r_d.prdata = r_q.seg_base;
            if (is_reg(paddr, `SDD_ADDR_LIMIT)) r_d.prdata = r_q.seg_limit;
            if (is_reg(paddr, `SDD_ADDR_ATTR))  r_d.prdata = attr_w;
            // Whole register readable; nothing of it is hidden
            if (is_reg(paddr, `SDD_ADDR_TBL_BASE)) r_d.prdata = r_q.tbl_base;
            if (is_reg(paddr, `SDD_ADDR_TBL_LIM)) begin
               r_d.prdata = {16'h0000, r_q.tbl_lim};
            end
            if (is_reg(paddr, `SDD_ADDR_OFFSET)) r_d.prdata = r_q.offset;
            if (is_reg(paddr, `SDD_ADDR_STATUS)) r_d.prdata = status_w;
         end
      end

      case (r_q.state)
         SDD_IDLE: begin
         end
         SDD_CHECK: begin
            r_d.valid       = 1'b0;
            r_d.limit_fault = 1'b0;
            r_d.vec_fault   = 1'b0;
            r_d.not_present = 1'b0;
            // Software-available bit is never read here
            if (!hi_w[`SDD_BIT_P]) begin
               r_d.not_present = 1'b1;
               r_d.fault_pulse = 1'b1;
               r_d.seg_base    = `SDD_ZERO32;
               r_d.seg_limit   = `SDD_ZERO32;
            end else begin
               r_d.valid     = 1'b1;
               r_d.seg_base  = {hi_w[31:24], hi_w[7:0], lo_w[31:16]};
               r_d.seg_limit = scaled_lim;
               // Expand-down segments get the same offset > limit check as every other segment
               if (r_q.chk_ofs && r_q.offset > scaled_lim) begin
                  r_d.limit_fault = 1'b1;
                  r_d.fault_pulse = 1'b1;
               end
            end
            if (r_q.chk_vec && ent_last > {16'h0000, r_q.tbl_lim}) begin
               r_d.vec_fault   = 1'b1;
               r_d.fault_pulse = 1'b1;
            end
            r_d.vec_addr = r_q.tbl_base + ent_ofs;
            r_d.descriptor_privilege_field       = hi_w[`SDD_DPL_MSB:`SDD_DPL_LSB];
            r_d.most_priv = hi_w[`SDD_DPL_MSB:`SDD_DPL_LSB] == 2'b00;
            r_d.code_data = hi_w[`SDD_BIT_S];
            r_d.exec      = hi_w[`SDD_BIT_EXEC];
            r_d.accessed  = hi_w[`SDD_BIT_ACC];
            r_d.conforming  = hi_w[`SDD_BIT_S] && hi_w[`SDD_BIT_CE];
            r_d.expand_down = !hi_w[`SDD_BIT_S] && hi_w[`SDD_BIT_CE];
            r_d.readable    = hi_w[`SDD_BIT_S] && hi_w[`SDD_BIT_RW];
            r_d.writable    = !hi_w[`SDD_BIT_S] && hi_w[`SDD_BIT_RW];
            // Size flag means operand width for code, stack width for data, nothing for system class
            r_d.wide_ops   = hi_w[`SDD_BIT_S] && hi_w[`SDD_BIT_EXEC]
                             && hi_w[`SDD_BIT_D];
            r_d.wide_stack = hi_w[`SDD_BIT_S] && !hi_w[`SDD_BIT_EXEC]
                             && hi_w[`SDD_BIT_D];
            r_d.sys_type  = hi_w[`SDD_BIT_S] ? 4'h0
                            : hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB];
            r_d.tss_avail = !hi_w[`SDD_BIT_S]
                            && hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_TSS32_AV;
            r_d.tss_busy  = !hi_w[`SDD_BIT_S]
                            && hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_TSS32_BSY;
            r_d.is_gate   = !hi_w[`SDD_BIT_S]
                            && (hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_CALL16
                             || hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_TASK
                             || hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_INT16
                             || hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_TRAP16
                             || hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_CALL32
                             || hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_INT32
                             || hi_w[`SDD_TYPE_MSB:`SDD_TYPE_LSB] == `SDD_ST_TRAP32);
            r_d.state = SDD_DONE;
         end
         SDD_DONE: begin
            r_d.busy  = 1'b0;
            r_d.state = SDD_IDLE;
         end
         default: begin
            r_d.state = SDD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_q          <= '0;
         r_q.state    <= SDD_IDLE;
         r_q.tbl_lim  <= `SDD_TBL_LIM_RESET;
      end else if (clk_en) begin
         r_q <= r_d;
      end
   end

   assign prdata          = r_q.prdata;
   assign pready          = r_q.pready;
   assign pslverr         = r_q.pslverr;
   assign seg_not_present = r_q.not_present;
   assign limit_fault     = r_q.limit_fault;
   assign vector_fault    = r_q.vec_fault;
   assign fault_pulse     = r_q.fault_pulse;
   assign decode_valid    = r_q.valid;
   assign wide_ops        = r_q.wide_ops;
   assign wide_stack      = r_q.wide_stack;
   assign desc_priv       = r_q.descriptor_privilege_field;

endmodule

`default_nettype wire

// >>> sdd_decoder_sva.sv
// Purpose: port-level checks for the segment descriptor decoder
// Assumes: clk_en held high in the bench; decode results land two edges after load
// Notes:   bound into every sdd_decoder instance
`timescale 1ns/1ps
`default_nettype none
`include "sdd_defs.svh"
module sdd_decoder_sva #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              clk_en,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              seg_not_present,
   input wire logic              limit_fault,
   input wire logic              vector_fault,
   input wire logic              fault_pulse,
   input wire logic              decode_valid,
   input wire logic              wide_ops,
   input wire logic              wide_stack,
   input wire logic [1:0]        desc_priv
);
   logic load_done;
   // True at the edge where the load write is acknowledged; results show one edge later
   assign load_done = psel && penable && pready && pwrite && (paddr == `SDD_ADDR_CTRL)
                      && pwdata[`SDD_CTRL_LOAD];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wait;
      psel && penable && !pready && clk_en;
   endsequence
   sequence s_fault;
      seg_not_present || limit_fault || vector_fault;
   endsequence
   property p_answer; s_wait |=> pready; endproperty
   property p_single; pready && clk_en |=> !pready; endproperty
   property p_origin; pready |-> $past(psel) && $past(penable); endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_np_excl; seg_not_present |-> !decode_valid && !limit_fault; endproperty
   property p_wide_excl; wide_ops |-> !wide_stack; endproperty
   property p_pulse_cause; $rose(fault_pulse) |-> $past(load_done) ##0 s_fault; endproperty
   property p_pulse_one; fault_pulse && clk_en |=> !fault_pulse; endproperty
   property p_priv_hold; $changed(desc_priv) |-> $past(load_done); endproperty
   property p_valid_hold; $changed(decode_valid) |-> $past(load_done); endproperty
   a_answer: assert property (p_answer) else $error("no pready after access cycle");
   a_single: assert property (p_single) else $error("pready longer than one cycle");
   a_origin: assert property (p_origin) else $error("pready without access phase");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_np_excl: assert property (p_np_excl) else $error("not-present with valid or limit");
   a_wide_excl: assert property (p_wide_excl) else $error("both width flags set");
   a_pulse_cause: assert property (p_pulse_cause) else $error("fault pulse without load");
   a_pulse_one: assert property (p_pulse_one) else $error("fault pulse too long");
   a_priv_hold: assert property (p_priv_hold) else $error("privilege moved without load");
   a_valid_hold: assert property (p_valid_hold) else $error("valid moved without load");
   c_load: cover property (load_done ##1 fault_pulse);
endmodule
bind sdd_decoder sdd_decoder_sva #(.ADDR_W(ADDR_W)) u_sva (
   .clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .seg_not_present(seg_not_present), .limit_fault(limit_fault),
   .vector_fault(vector_fault), .fault_pulse(fault_pulse), .decode_valid(decode_valid),
   .wide_ops(wide_ops), .wide_stack(wide_stack), .desc_priv(desc_priv));
`default_nettype wire

// >>> sdd_desc_mem.sv
// Purpose: byte-wide system memory holding eight descriptor slots
// Assumes: bench stores a descriptor, then fetches its words at +0 and +4
// Notes:   unwritten bytes stay unknown so stale fetches show up
`timescale 1ns/1ps
`default_nettype none
module sdd_desc_mem (
   input  wire logic        clk,
   input  wire logic        we,
   input  wire logic [2:0]  idx,
   input  wire logic [63:0] wdesc,
   output logic [31:0]      word_lo,
   output logic [31:0]      word_hi
);
   logic [7:0] bytes_q [64];
   // Each slot is eight bytes, little-endian
   always_ff @(posedge clk) begin
      if (we) begin
         for (int b = 0; b < 8; b++) begin
            bytes_q[{idx, b[2:0]}] <= wdesc[8*b +: 8];
         end
      end
   end
   assign word_lo = {bytes_q[{idx,3'd3}], bytes_q[{idx,3'd2}], bytes_q[{idx,3'd1}], bytes_q[{idx,3'd0}]};
   assign word_hi = {bytes_q[{idx,3'd7}], bytes_q[{idx,3'd6}], bytes_q[{idx,3'd5}], bytes_q[{idx,3'd4}]};
endmodule
`default_nettype wire

// >>> segment_descriptor_decoder_tb.sv
// Purpose: self-checking bench for the segment descriptor decoder
// Assumes: APB master waits for pready; decode results settle two edges after load
// Notes:   clk_en held high, so freeze behaviour is left to review
`timescale 1ns/1ps
`default_nettype none
`include "sdd_defs.svh"
module segment_descriptor_decoder_tb;
   logic clk, reset, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, word_lo, word_hi;
   logic [3:0]  pstrb;
   logic snp, lf, vf, fp, dv, wo, ws, mem_we;
   logic [1:0]  dp;
   logic [2:0]  mem_idx;
   logic [63:0] mem_wdesc;
   int miscompares, checked, cycles;
   sdd_decoder u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .seg_not_present(snp),
      .limit_fault(lf), .vector_fault(vf), .fault_pulse(fp), .decode_valid(dv),
      .wide_ops(wo), .wide_stack(ws), .desc_priv(dp));
   sdd_desc_mem u_mem (.clk(clk), .we(mem_we), .idx(mem_idx), .wdesc(mem_wdesc),
      .word_lo(word_lo), .word_hi(word_hi));
   always #20 clk = ~clk;
   // fl = {g, d, avl, p, dpl, s, unused}
   function automatic logic [63:0] mk(input logic [31:0] b, input logic [19:0] l,
                                      input logic [7:0] fl, input logic [3:0] t);
      return {b[31:24], fl[7], fl[6], 1'b0, fl[5], l[19:16], fl[4], fl[3:2], fl[1], t,
              b[23:16], b[15:0], l[15:0]};
   endfunction
   function automatic logic [31:0] attr_exp(input logic s, input logic [3:0] t,
                                            input logic [1:0] descriptor_privilege_field, input logic d);
      logic [31:0] a;
      a = 32'h0000_0000;
      a[0] = s & t[3] & d;
      a[1] = s & ~t[3] & d;
      a[3:2] = descriptor_privilege_field;
      a[4] = (descriptor_privilege_field == 2'b00);
      a[5] = s;
      a[6] = t[3];
      a[7] = s & t[2];
      a[8] = ~s & t[2];
      a[9] = s & t[1];
      a[10] = ~s & t[1];
      a[11] = t[0];
      if (!s) a[15:12] = t;
      a[16] = !s && (t inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF});
      a[17] = !s && (t == `SDD_ST_TSS32_AV);
      a[18] = !s && (t == `SDD_ST_TSS32_BSY);
      return a;
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(n, r, exp);
   endtask
   // Descriptor goes through memory first, so the word split is exercised
   task automatic load(input logic [63:0] desc, input logic [31:0] ctrl, output logic f);
      mem_wdesc <= desc; mem_idx <= mem_idx + 3'd1; mem_we <= 1'b1;
      @(posedge clk);
      mem_we <= 1'b0;
      @(posedge clk);
      wr(`SDD_ADDR_LO, word_lo);
      wr(`SDD_ADDR_HI, word_hi);
      wr(`SDD_ADDR_CTRL, ctrl | 32'h0000_0001);
      // Pulse stands only in the cycle right after the acknowledge edge
      #1 f = fp;
      @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      rdc("tbl_lim_rst", `SDD_ADDR_TBL_LIM, 32'h0000_FFFF);
      chk("outs_rst", {snp, lf, vf, fp, dv, wo, ws, dp}, 32'h0000_0000);
      apb(1'b0, 12'h040, 32'h0000_0000, r, e);
      chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
      wr(`SDD_ADDR_TBL_BASE, 32'hC012_3400);
      wr(`SDD_ADDR_TBL_LIM, 32'h0000_07FF);
      rdc("tbl_base", `SDD_ADDR_TBL_BASE, 32'hC012_3400);
      rdc("tbl_lim", `SDD_ADDR_TBL_LIM, 32'h0000_07FF);
   endtask
   task automatic t_base_limit;
      logic f;
      for (int g = 0; g < 2; g++) begin
         load(mk(32'h89AB_CDEF, 20'hA_5C3E, {g[0], 3'b001, 2'b00, 2'b10}, 4'h2), 0, f);
         rdc("base", `SDD_ADDR_BASE, 32'h89AB_CDEF);
         rdc("limit", `SDD_ADDR_LIMIT, g ? 32'hA5C3_EFFF : 32'h000A_5C3E);
      end
   endtask
   task automatic t_attr;
      logic [31:0] e, m, r;
      logic f, er;
      for (int i = 0; i < 32; i++) begin
         load(mk(0, 0, {1'b0, i[2], i[0], 1'b1, i[1:0], i[4], 1'b0}, i[3:0]), 0, f);
         e = attr_exp(i[4], i[3:0], i[1:0], i[2]);
         m = 32'h0007_FFFF;
         apb(1'b0, `SDD_ADDR_ATTR, 32'h0000_0000, r, er);
         chk("attr", r & m, e);
         chk("priv", {30'h0, dp}, {30'h0, i[1:0]});
         chk("width", {30'h0, wo, ws}, {30'h0, e[0], e[1]});
         chk("valid", {31'h0, dv}, 32'h0000_0001);
      end
   endtask
   task automatic t_not_present;
      logic f;
      load(mk(32'h0040_0000, 20'h0_0001, 8'b0000_0010, 4'h2), 32'h0000_0004, f);
      chk("np_flags", {f, snp, dv}, 32'h0000_0006);
      rdc("np_base", `SDD_ADDR_BASE, 32'h0000_0000);
      rdc("np_limit", `SDD_ADDR_LIMIT, 32'h0000_0000);
      load(mk(0, 0, 8'b0001_0010, 4'h2), 0, f);
      chk("np_clear", {f, snp, dv}, 32'h0000_0001);
   endtask
   task automatic t_limit;
      logic [31:0] ofs [4] = '{32'h0000_0010, 32'h0000_0011, 32'h0001_0FFF, 32'h0001_1000};
      logic f;
      for (int i = 0; i < 4; i++) begin
         wr(`SDD_ADDR_OFFSET, ofs[i]);
         load(mk(0, 20'h0_0010, {i[1], 7'b0001_0010}, 4'h2), 32'h0000_0004, f);
         chk("limit_fault", {30'h0, lf, f}, {30'h0, i[0], i[0]});
      end
   endtask
   task automatic t_vector;
      logic [7:0] vec [4] = '{8'd15, 8'd16, 8'd31, 8'd32};
      logic f;
      wr(`SDD_ADDR_TBL_LIM, 32'h0000_007F);
      for (int i = 0; i < 4; i++) begin
         load(mk(0, 0, 8'b0001_0010, 4'h2), {16'h0, vec[i], 4'h0, 1'b1, 1'b0, !i[1], 1'b0}, f);
         chk("vector_fault", {30'h0, vf, f}, {30'h0, i[0], i[0]});
      end
   endtask
   task automatic wrap_up;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up;
      end
   end
   initial begin
      clk = 0; reset = 1; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; pstrb = 4'hF; mem_we = 0; mem_idx = 0; mem_wdesc = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_base_limit;
      t_attr;
      t_not_present;
      t_limit;
      t_vector;
      wrap_up;
   end
endmodule
`default_nettype wire
